// [ssm_pkg.sv]
// Package with register map, field layout, encodings and timing counts for the supervisor control.
// Notes on behaviour
// - Full-performance core supervisor settles in about 2us.
// - Raising core level in full-performance mode causes reset.
// - Normal-mode core side settles in about 150us.
// - Interrupt within 1us of deep entry hangs if a hazard was latched at entry.
// - Hang cleared by reset or power-up clear.
// - Hazard needs fast core setup and supply drop, or a settle still pending.
// - Wake class fast unless core supervisor normal.
// - Manual core supervisor: off unless sleep-keep set.
// - Automatic core supervisor: normal only when keep+fullperf.
// - Core monitor follows enable, fullperf and auto.
// - Supply supervisor awake state follows enable and fullperf.
// - Supply supervisor sleeps like the core supervisor.
// - Supply monitor follows enable, fullperf and auto.
// - Hazard is supply unit normal awake, off asleep.
package ssm_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          CNT_W           = 16;
   localparam logic [7:0]  OFS_CORE_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_SUPPLY_CTRL = 8'h04;
   localparam logic [7:0]  OFS_POWER_FLAG  = 8'h08;
   localparam logic [7:0]  OFS_INT_STATUS  = 8'h0c;
   localparam logic [7:0]  OFS_INT_MASK    = 8'h10;
   localparam logic [7:0]  OFS_CORE_LEVEL  = 8'h14;
   localparam int          BIT_SUPV_EN     = 0;
   localparam int          BIT_SLEEP_KEEP  = 1;
   localparam int          BIT_SUPV_FP     = 2;
   localparam int          BIT_MON_EN      = 3;
   localparam int          BIT_MON_FP      = 4;
   localparam int          BIT_AUTO        = 5;
   localparam int          CTRL_W          = 6;
   localparam logic [5:0]  CTRL_RESET      = 6'h00;
   localparam int          INT_CORE_DONE   = 0;
   localparam int          INT_SUPPLY_DONE = 1;
   localparam int          INT_SUPV_RESET  = 2;
   localparam int          INT_WAKE_HANG   = 3;
   localparam int          INT_W           = 4;
   localparam logic [3:0]  INT_MASK_RESET  = 4'h0;
   localparam logic [1:0]  LEVEL_RESET     = 2'h0;
   localparam logic [2:0]  MODE_SLEEP2     = 3'h3;
   localparam int          CLK_PERIOD_NS   = 20;
   localparam int          SETTLE_FAST_NS  = 2000;
   localparam int          SETTLE_SLOW_NS  = 150000;
   localparam int          CORE_RAMP_NS    = 100000;
   localparam int          WAKE_WINDOW_NS  = 1000;
   localparam int          SETTLE_FAST_CYC = (SETTLE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SETTLE_SLOW_CYC = (SETTLE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CORE_RAMP_CYC   = (CORE_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          WAKE_WINDOW_CYC = WAKE_WINDOW_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      SSM_OFF    = 2'b00,
      SSM_NORMAL = 2'b01,
      SSM_FULL   = 2'b10
   } ssm_unit_t;
   typedef enum logic [2:0] {
      SSM_ST_IDLE   = 3'b001,
      SSM_ST_WINDOW = 3'b010,
      SSM_ST_HUNG   = 3'b100
   } ssm_state_t;
endpackage

// [ssm_mode_decode.sv]
// Per-mode state decode for one supervisor or monitor.
`timescale 1ns/1ps
`default_nettype none
module ssm_mode_decode import ssm_pkg::*; #(
   parameter bit IS_MONITOR = 1'b0
) (
   input  wire logic      enable_in,
   input  wire logic      sleep_keep_in,
   input  wire logic      fullperf_in,
   input  wire logic      auto_ctrl_in,
   input  wire logic      deep_in,
   output var ssm_unit_t  state_out
);
   wire ssm_unit_t awake_state = fullperf_in ? SSM_FULL : SSM_NORMAL;
   wire            keep_awake  = IS_MONITOR ? 1'b1 : sleep_keep_in;
   wire            auto_normal = IS_MONITOR ? fullperf_in : (sleep_keep_in & fullperf_in);
   always_comb begin
      if (!enable_in) begin
         state_out = SSM_OFF;
      end else if (!deep_in) begin
         state_out = awake_state;
      end else if (auto_ctrl_in) begin
         state_out = auto_normal ? SSM_NORMAL : SSM_OFF;
      end else begin
         state_out = keep_awake ? awake_state : SSM_OFF;
      end
   end
endmodule
`default_nettype wire

// [ssm_settle_timer.sv]
// Comparator settling timer with a pending flag and a completion pulse.
`timescale 1ns/1ps
`default_nettype none
module ssm_settle_timer import ssm_pkg::*; #(
   parameter int FAST_CYCLES = SETTLE_FAST_CYC,
   parameter int SLOW_CYCLES = SETTLE_SLOW_CYC
) (
   input  wire logic      clock_in,
   input  wire logic      reset_n_in,
   input  wire logic      start_in,
   input  wire logic      slow_in,
   output logic           busy_out,
   output logic           done_out
);
   logic [CNT_W-1:0] count;
   wire  [CNT_W-1:0] load = slow_in ? CNT_W'(SLOW_CYCLES) : CNT_W'(FAST_CYCLES);
   assign done_out = busy_out && (count == CNT_W'(1)) && !start_in;
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count    <= '0;
         busy_out <= 1'b0;
      end else if (start_in) begin
         count    <= load;
         busy_out <= 1'b1;
      end else if (busy_out) begin
         count    <= count - CNT_W'(1);
         busy_out <= (count != CNT_W'(1));
      end
   end
   // A restart may switch speed and shorten the wait, so the checks run from the last start.
   logic [CNT_W-1:0] age;
   logic             age_slow;
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         age      <= '0;
         age_slow <= 1'b0;
      end else if (start_in) begin
         age      <= CNT_W'(1);
         age_slow <= slow_in;
      end else if (busy_out) begin
         age      <= age + CNT_W'(1);
      end
   end
   property p_fast_hold;
      @(posedge clock_in) disable iff (!reset_n_in)
         (!age_slow && age != '0 && age <= CNT_W'(FAST_CYCLES)) |-> busy_out;
   endproperty
   a_fast_hold: assert property (p_fast_hold) else $error("Fast settle ended early.");
   property p_slow_hold;
      @(posedge clock_in) disable iff (!reset_n_in)
         (age_slow && age != '0 && age <= CNT_W'(SLOW_CYCLES)) |-> busy_out;
   endproperty
   a_slow_hold: assert property (p_slow_hold) else $error("Slow settle ended early.");
endmodule
`default_nettype wire

// [ssm_top.sv]
// Supervisor mode control with settling timers, wake hazard tracking and an APB register file.
`timescale 1ns/1ps
`default_nettype none
module ssm_top import ssm_pkg::*; #(
   parameter int SLOW_SETTLE_CYCLES = SETTLE_SLOW_CYC,
   parameter int CORE_RAMP_CYCLES   = CORE_RAMP_CYC
) (
   input  wire logic               clock_in,
   input  wire logic               reset_n_in,
   input  wire logic [ADDR_W-1:0]  paddr_in,
   input  wire logic               psel_in,
   input  wire logic               penable_in,
   input  wire logic               pwrite_in,
   input  wire logic [31:0]        pwdata_in,
   output logic      [31:0]        prdata_out,
   output logic                    pready_out,
   output logic                    pslverr_out,
   input  wire logic [2:0]         power_mode_in,
   input  wire logic               wake_irq_in,
   input  wire logic               power_up_clear_in,
   output var ssm_unit_t           core_supv_state_out,
   output var ssm_unit_t           core_mon_state_out,
   output var ssm_unit_t           supply_supv_state_out,
   output var ssm_unit_t           supply_mon_state_out,
   output logic                    wake_fast_out,
   output logic                    core_delay_pending_out,
   output logic                    supply_delay_pending_out,
   output logic                    supv_reset_out,
   output logic                    cpu_wake_out,
   output logic                    wake_hang_out,
   output logic                    irq_out
);
   logic [CTRL_W-1:0] core_side_control;
   logic [CTRL_W-1:0] supply_side_control;
   logic [INT_W-1:0]  int_status;
   logic [INT_W-1:0]  int_mask;
   logic [1:0]        core_level;
   logic [CNT_W-1:0]  ramp_count;
   logic [CNT_W-1:0]  window_count;
   logic              deep_prev;
   logic              hazard_latched;
   ssm_state_t        state;
   ssm_state_t        next_state;

   // Bus decode.
   wire setup_phase  = psel_in && !penable_in;
   wire access_done  = psel_in && penable_in && pready_out;
   wire write_done   = access_done && pwrite_in;
   wire hit_core     = (paddr_in == OFS_CORE_CTRL);
   wire hit_supply   = (paddr_in == OFS_SUPPLY_CTRL);
   wire hit_flag     = (paddr_in == OFS_POWER_FLAG);
   wire hit_status   = (paddr_in == OFS_INT_STATUS);
   wire hit_mask     = (paddr_in == OFS_INT_MASK);
   wire hit_level    = (paddr_in == OFS_CORE_LEVEL);
   wire mapped       = hit_core | hit_supply | hit_flag | hit_status | hit_mask | hit_level;
   wire wr_core      = write_done && hit_core;
   wire wr_supply    = write_done && hit_supply;
   wire wr_status    = write_done && hit_status;
   wire wr_mask      = write_done && hit_mask;
   wire wr_level     = write_done && hit_level;
   wire level_raise  = wr_level && (pwdata_in[1:0] > core_level);

   // Control fields.
   wire core_supv_enable       = core_side_control[BIT_SUPV_EN];
   wire core_supv_sleep_keep   = core_side_control[BIT_SLEEP_KEEP];
   wire core_supv_fullperf     = core_side_control[BIT_SUPV_FP];
   wire core_mon_enable        = core_side_control[BIT_MON_EN];
   wire core_mon_fullperf      = core_side_control[BIT_MON_FP];
   wire core_auto_ctrl         = core_side_control[BIT_AUTO];
   wire supply_supv_enable     = supply_side_control[BIT_SUPV_EN];
   wire supply_supv_sleep_keep = supply_side_control[BIT_SLEEP_KEEP];
   wire supply_supv_fullperf   = supply_side_control[BIT_SUPV_FP];
   wire supply_mon_enable      = supply_side_control[BIT_MON_EN];
   wire supply_mon_fullperf    = supply_side_control[BIT_MON_FP];
   wire supply_auto_ctrl       = supply_side_control[BIT_AUTO];

   // Power mode decode.
   wire deep        = (power_mode_in >= MODE_SLEEP2);
   wire deep_entry  = deep && !deep_prev;
   wire core_fast   = !core_supv_enable || core_supv_fullperf;
   wire supply_supv_drop = supply_supv_enable && !supply_supv_fullperf
                           && (!supply_supv_sleep_keep || supply_auto_ctrl);
   wire supply_mon_drop  = supply_mon_enable && !supply_mon_fullperf && supply_auto_ctrl;
   wire config_hazard = core_fast && (supply_supv_drop || supply_mon_drop);
   wire pending_any   = core_delay_pending_out || supply_delay_pending_out;
   wire hazard_now    = config_hazard || pending_any;

   // Settling timers.
   wire core_start   = wr_core || level_raise;
   wire written_slow = pwdata_in[BIT_SUPV_EN] && !pwdata_in[BIT_SUPV_FP];
   wire core_slow    = wr_core ? written_slow : (core_supv_enable && !core_supv_fullperf);
   wire supply_slow  = wr_supply ? written_slow : (supply_supv_enable && !supply_supv_fullperf);
   wire ramp_busy    = (ramp_count != '0);
   wire core_done;
   wire supply_done;
   wire core_fp_live = core_supv_enable && core_supv_fullperf;
   wire reset_event  = core_done && ramp_busy && core_fp_live;

   ssm_settle_timer #(
      .FAST_CYCLES (SETTLE_FAST_CYC),
      .SLOW_CYCLES (SLOW_SETTLE_CYCLES)
   ) u_core_timer (
      .clock_in   (clock_in),
      .reset_n_in (reset_n_in),
      .start_in   (core_start),
      .slow_in    (core_slow),
      .busy_out   (core_delay_pending_out),
      .done_out   (core_done)
   );
   ssm_settle_timer #(
      .FAST_CYCLES (SETTLE_FAST_CYC),
      .SLOW_CYCLES (SLOW_SETTLE_CYCLES)
   ) u_supply_timer (
      .clock_in   (clock_in),
      .reset_n_in (reset_n_in),
      .start_in   (wr_supply),
      .slow_in    (supply_slow),
      .busy_out   (supply_delay_pending_out),
      .done_out   (supply_done)
   );

   // Unit state decode.
   ssm_unit_t next_core_supv;
   ssm_unit_t next_core_mon;
   ssm_unit_t next_supply_supv;
   ssm_unit_t next_supply_mon;
   ssm_mode_decode #(.IS_MONITOR (1'b0)) u_core_supv (
      .enable_in     (core_supv_enable),
      .sleep_keep_in (core_supv_sleep_keep),
      .fullperf_in   (core_supv_fullperf),
      .auto_ctrl_in  (core_auto_ctrl),
      .deep_in       (deep),
      .state_out     (next_core_supv)
   );
   ssm_mode_decode #(.IS_MONITOR (1'b1)) u_core_mon (
      .enable_in     (core_mon_enable),
      .sleep_keep_in (1'b0),
      .fullperf_in   (core_mon_fullperf),
      .auto_ctrl_in  (core_auto_ctrl),
      .deep_in       (deep),
      .state_out     (next_core_mon)
   );
   ssm_mode_decode #(.IS_MONITOR (1'b0)) u_supply_supv (
      .enable_in     (supply_supv_enable),
      .sleep_keep_in (supply_supv_sleep_keep),
      .fullperf_in   (supply_supv_fullperf),
      .auto_ctrl_in  (supply_auto_ctrl),
      .deep_in       (deep),
      .state_out     (next_supply_supv)
   );
   ssm_mode_decode #(.IS_MONITOR (1'b1)) u_supply_mon (
      .enable_in     (supply_mon_enable),
      .sleep_keep_in (1'b0),
      .fullperf_in   (supply_mon_fullperf),
      .auto_ctrl_in  (supply_auto_ctrl),
      .deep_in       (deep),
      .state_out     (next_supply_mon)
   );

   // Wake hazard state machine.
   wire window_end = (window_count == '0);
   always_comb begin
      next_state = state;
      unique case (state)
         SSM_ST_IDLE: begin
            if (deep_entry) begin
               next_state = SSM_ST_WINDOW;
            end
         end
         SSM_ST_WINDOW: begin
            if (wake_irq_in && hazard_latched) begin
               next_state = SSM_ST_HUNG;
            end else if (!deep || window_end) begin
               next_state = SSM_ST_IDLE;
            end
         end
         SSM_ST_HUNG: begin
            if (power_up_clear_in) begin
               next_state = SSM_ST_IDLE;
            end
         end
         default: begin
            next_state = SSM_ST_IDLE;
         end
      endcase
   end
   wire hang_event = (state == SSM_ST_WINDOW) && (next_state == SSM_ST_HUNG);
   wire next_hung  = (next_state == SSM_ST_HUNG);

   // Register read mux.
   wire [31:0] read_mux =
      hit_core   ? {26'h0, core_side_control} :
      hit_supply ? {26'h0, supply_side_control} :
      hit_flag   ? {29'h0, wake_hang_out, supply_delay_pending_out, core_delay_pending_out} :
      hit_status ? {28'h0, int_status} :
      hit_mask   ? {28'h0, int_mask} :
      hit_level  ? {30'h0, core_level} : 32'h0;
   wire [INT_W-1:0] int_events = {hang_event, reset_event, supply_done, core_done};
   wire [INT_W-1:0] int_clear  = wr_status ? pwdata_in[INT_W-1:0] : '0;
   // Setting wins over a write-one clear in the same cycle.
   wire [INT_W-1:0] next_status = (int_status & ~int_clear) | int_events;

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0;
      end else begin
         pready_out  <= setup_phase;
         pslverr_out <= setup_phase && !mapped;
         prdata_out  <= (setup_phase && !pwrite_in) ? read_mux : 32'h0;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         core_side_control   <= CTRL_RESET;
         supply_side_control <= CTRL_RESET;
         int_mask            <= INT_MASK_RESET;
         core_level          <= LEVEL_RESET;
      end else begin
         if (wr_core) core_side_control <= pwdata_in[CTRL_W-1:0];
         if (wr_supply) supply_side_control <= pwdata_in[CTRL_W-1:0];
         if (wr_mask) int_mask <= pwdata_in[INT_W-1:0];
         if (wr_level) core_level <= pwdata_in[1:0];
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         int_status <= '0;
         irq_out    <= 1'b0;
      end else begin
         int_status <= next_status;
         irq_out    <= |(next_status & int_mask);
      end
   end

   // The ramp models the core rail climbing; the supervisor may only judge it afterwards.
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ramp_count     <= '0;
         supv_reset_out <= 1'b0;
      end else begin
         if (level_raise) begin
            ramp_count <= CNT_W'(CORE_RAMP_CYCLES);
         end else if (ramp_busy) begin
            ramp_count <= ramp_count - CNT_W'(1);
         end
         supv_reset_out <= reset_event;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state          <= SSM_ST_IDLE;
         deep_prev      <= 1'b0;
         hazard_latched <= 1'b0;
         window_count   <= '0;
         wake_hang_out  <= 1'b0;
         cpu_wake_out   <= 1'b0;
      end else begin
         state         <= next_state;
         deep_prev     <= deep;
         wake_hang_out <= next_hung;
         cpu_wake_out  <= wake_irq_in && !next_hung;
         if (deep_entry) begin
            hazard_latched <= hazard_now;
            window_count   <= CNT_W'(WAKE_WINDOW_CYC - 1);
         end else if (!window_end) begin
            window_count <= window_count - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         core_supv_state_out   <= SSM_OFF;
         core_mon_state_out    <= SSM_OFF;
         supply_supv_state_out <= SSM_OFF;
         supply_mon_state_out  <= SSM_OFF;
         wake_fast_out         <= 1'b1;
      end else begin
         core_supv_state_out   <= next_core_supv;
         core_mon_state_out    <= next_core_mon;
         supply_supv_state_out <= next_supply_supv;
         supply_mon_state_out  <= next_supply_mon;
         wake_fast_out         <= core_fast;
      end
   end

   property p_pending_set;
      @(posedge clock_in) disable iff (!reset_n_in)
         wr_core |=> core_delay_pending_out ##1 core_delay_pending_out;
   endproperty
   a_pending_set: assert property (p_pending_set) else $error("Core pending flag not raised.");

   // Counts how long full performance stays untouched after a level raise.
   logic [CNT_W-1:0] fp_raise_age;
   wire fp_untouched = core_fp_live && !core_start;
   wire fp_age_live  = (fp_raise_age != '0) && fp_untouched;
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fp_raise_age <= '0;
      end else if (level_raise && core_fp_live && !wr_core) begin
         fp_raise_age <= CNT_W'(1);
      end else if (fp_age_live && fp_raise_age < CNT_W'(SETTLE_FAST_CYC)) begin
         fp_raise_age <= fp_raise_age + CNT_W'(1);
      end else begin
         fp_raise_age <= '0;
      end
   end
   property p_fp_reset;
      @(posedge clock_in) disable iff (!reset_n_in)
         (fp_raise_age == CNT_W'(SETTLE_FAST_CYC) && fp_untouched) |=> supv_reset_out;
   endproperty
   a_fp_reset: assert property (p_fp_reset) else $error("No reset after raise in fast mode.");

   property p_hang;
      @(posedge clock_in) disable iff (!reset_n_in)
         (state == SSM_ST_WINDOW && wake_irq_in && hazard_latched)
         |=> wake_hang_out && !cpu_wake_out;
   endproperty
   a_hang: assert property (p_hang) else $error("Missed wake-up not entered.");

   property p_recover;
      @(posedge clock_in) disable iff (!reset_n_in)
         (wake_hang_out && power_up_clear_in) |=> !wake_hang_out;
   endproperty
   a_recover: assert property (p_recover) else $error("Power-up clear did not recover.");

   property p_wake_class;
      @(posedge clock_in) disable iff (!reset_n_in)
         (core_supv_enable && !core_supv_fullperf) ##1 $stable(core_side_control)
         |-> !wake_fast_out;
   endproperty
   a_wake_class: assert property (p_wake_class) else $error("Wake class wrong.");

   property p_core_manual_off;
      @(posedge clock_in) disable iff (!reset_n_in)
         (deep && !core_auto_ctrl && !core_supv_sleep_keep) |=> core_supv_state_out == SSM_OFF;
   endproperty
   a_core_manual_off: assert property (p_core_manual_off) else $error("Core supervisor on.");

   property p_core_auto;
      @(posedge clock_in) disable iff (!reset_n_in)
         (deep && core_auto_ctrl && core_supv_enable) |=>
         core_supv_state_out == (($past(core_supv_sleep_keep) && $past(core_supv_fullperf))
                                 ? SSM_NORMAL : SSM_OFF);
   endproperty
   a_core_auto: assert property (p_core_auto) else $error("Core auto state wrong.");

   property p_supply_awake;
      @(posedge clock_in) disable iff (!reset_n_in)
         (!deep && supply_supv_enable && supply_supv_fullperf)
         |=> supply_supv_state_out == SSM_FULL;
   endproperty
   a_supply_awake: assert property (p_supply_awake) else $error("Supply supervisor not full.");

   property p_mon_auto;
      @(posedge clock_in) disable iff (!reset_n_in)
         (deep && supply_auto_ctrl && supply_mon_enable && !supply_mon_fullperf)
         |=> supply_mon_state_out == SSM_OFF;
   endproperty
   a_mon_auto: assert property (p_mon_auto) else $error("Supply monitor not off.");
endmodule
`default_nettype wire

// [supply_supervisor_mode_control_tb_top.sv]
// Self-checking testbench for the supervisor mode control block.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_mode_control_tb_top import ssm_pkg::*;;
   logic        clock_in, reset_n_in, psel, penable, pwrite, wake_irq, power_up_clear;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err;
   logic [2:0]  pmode;
   ssm_unit_t   cs, cm, ss, sm;
   logic        wfast, cpend, spend, sreset, cwake, hang, irq;
   int          n_fail, total_checks, cyc, n;
   ssm_top #(.SLOW_SETTLE_CYCLES(300), .CORE_RAMP_CYCLES(200)) uut (
      .clock_in(clock_in), .reset_n_in(reset_n_in), .paddr_in(paddr), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .power_mode_in(pmode),
      .wake_irq_in(wake_irq), .power_up_clear_in(power_up_clear), .core_supv_state_out(cs),
      .core_mon_state_out(cm), .supply_supv_state_out(ss), .supply_mon_state_out(sm),
      .wake_fast_out(wfast), .core_delay_pending_out(cpend),
      .supply_delay_pending_out(spend), .supv_reset_out(sreset), .cpu_wake_out(cwake),
      .wake_hang_out(hang), .irq_out(irq));
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   task automatic close_out();
      if (n_fail == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail = n_fail + 1;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // The master holds every request field until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock_in);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      do begin
         @(posedge clock_in);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      chk("pready", 1, pready);
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // Expected state of one unit, worked out from the mode tables.
   function automatic logic [1:0] unit_exp(input logic en, keep, fp, auto_c, deep, mon);
      if (!en) return SSM_OFF;
      if (!deep || (mon && !auto_c)) return fp ? SSM_FULL : SSM_NORMAL;
      if (mon) return fp ? SSM_NORMAL : SSM_OFF;
      if (auto_c) return (keep && fp) ? SSM_NORMAL : SSM_OFF;
      return keep ? (fp ? SSM_FULL : SSM_NORMAL) : SSM_OFF;
   endfunction
   task automatic settle();
      n = 0;
      do begin
         @(posedge clock_in);
         if (cpend === 1'b1) n++;
      end while ((cpend !== 1'b0 || spend !== 1'b0) && n < 2000);
      chk("settle_done", 0, cpend | spend);
   endtask
   task automatic deep_wake(input logic [5:0] sup, input logic exp_hang, input int dly);
      apb(1, OFS_CORE_CTRL, 32'h05);
      apb(1, OFS_SUPPLY_CTRL, {26'h0, sup});
      @(posedge clock_in);
      chk("supply_pending", 1, spend);
      settle();
      apb(0, OFS_INT_STATUS, 0);
      chk("supply_done", 1, rd[INT_SUPPLY_DONE]);
      apb(1, OFS_INT_STATUS, 32'h0f);
      pmode <= 3'h4;
      repeat (dly) @(posedge clock_in);
      wake_irq <= 1'b1;
      repeat (3) @(posedge clock_in);
      chk("wake_hang", exp_hang, hang);
      chk("cpu_wake", !exp_hang, cwake);
      chk("irq_masked", 0, irq);
      wake_irq <= 1'b0; power_up_clear <= 1'b1;
      @(posedge clock_in);
      power_up_clear <= 1'b0; pmode <= 3'h0;
      repeat (2) @(posedge clock_in);
      chk("hang_cleared", 0, hang);
   endtask
   initial begin
      n_fail = 0; total_checks = 0; cyc = 0; reset_n_in = 1'b0; psel = 0; penable = 0;
      pwrite = 0; paddr = 0; pwdata = 0; pmode = 0; wake_irq = 0; power_up_clear = 0;
      repeat (5) @(posedge clock_in);
      reset_n_in <= 1'b1;
      chk("reset_wake_fast", 1, wfast);
      apb(0, OFS_CORE_CTRL, 0);
      chk("core_ctrl_reset", 0, rd);
      apb(0, OFS_INT_MASK, 0);
      chk("mask_reset", 0, rd);
      apb(0, 8'h18, 0);
      chk("unmapped_err", 1, err);
      chk("unmapped_data", 0, rd);
      for (int v = 0; v < 64; v++) begin
         apb(1, OFS_CORE_CTRL, v);
         apb(1, OFS_SUPPLY_CTRL, v);
         for (int d = 0; d < 2; d++) begin
            pmode <= d ? 3'(3 + v % 3) : 3'(v % 3);
            repeat (3) @(posedge clock_in);
            chk("core_supv", unit_exp(v[0], v[1], v[2], v[5], d, 0), cs);
            chk("core_mon", unit_exp(v[3], 0, v[4], v[5], d, 1), cm);
            chk("supply_supv", unit_exp(v[0], v[1], v[2], v[5], d, 0), ss);
            chk("supply_mon", unit_exp(v[3], 0, v[4], v[5], d, 1), sm);
            chk("wake_fast", !v[0] || v[2], wfast);
         end
      end
      pmode <= 3'h0;
      settle();
      apb(1, OFS_INT_STATUS, 32'h0f);
      apb(1, OFS_INT_MASK, 32'h01);
      apb(1, OFS_CORE_CTRL, 32'h05);
      settle();
      chk("fast_settle_cycles", SETTLE_FAST_CYC, n);
      apb(0, OFS_INT_STATUS, 0);
      chk("done_status", 1, rd[INT_CORE_DONE]);
      chk("irq_level", 1, irq);
      apb(1, OFS_INT_STATUS, 32'h01);
      apb(0, OFS_POWER_FLAG, 0);
      chk("flags_clear", 0, rd);
      chk("irq_after_clear", 0, irq);
      apb(1, OFS_CORE_CTRL, 32'h01);
      settle();
      chk("slow_settle_cycles", 300, n);
      // A raised level in full performance must trip the supervisor.
      apb(1, OFS_CORE_CTRL, 32'h05);
      settle();
      apb(1, OFS_CORE_LEVEL, 32'h01);
      n = 0;
      while (sreset !== 1'b1 && n < 400) begin
         @(posedge clock_in);
         n++;
      end
      chk("fullperf_raise_reset", 1, sreset);
      apb(0, OFS_INT_STATUS, 0);
      chk("reset_status", 1, rd[INT_SUPV_RESET]);
      apb(1, OFS_CORE_CTRL, 32'h01);
      settle();
      apb(1, OFS_INT_STATUS, 32'h0f);
      apb(1, OFS_CORE_LEVEL, 32'h02);
      settle();
      apb(0, OFS_INT_STATUS, 0);
      chk("normal_raise_no_reset", 0, rd[INT_SUPV_RESET]);
      deep_wake(6'h01, 1, 2);
      deep_wake(6'h03, 0, 2);
      deep_wake(6'h01, 0, 60);
      close_out();
   end
endmodule
`default_nettype wire
